// [rsa_defines.svh]
`ifndef RSA_DEFINES_SVH
`define RSA_DEFINES_SVH

// register byte offsets
`define RSA_OFS_RANGE 8'h14
`define RSA_OFS_ALARM 8'h20
`define RSA_OFS_UPPER 8'h24
`define RSA_OFS_LOWER 8'h28
`define RSA_OFS_ISTAT 8'h30
`define RSA_OFS_IMASK 8'h34

// range register fields
`define RSA_RANGE_MSB 3
`define RSA_RANGE_LSB 0
`define RSA_REFOFF_BIT 6

// alarm register fields
`define RSA_ACT_SUP_LOW_BIT 15
`define RSA_ACT_SUP_HIGH_BIT 14
`define RSA_ACT_IN_HIGH_BIT 11
`define RSA_ACT_IN_LOW_BIT 10
`define RSA_TRP_MSB 7
`define RSA_TRP_LSB 4
`define RSA_SUM_BIT 0

// reset values
`define RSA_RANGE_RST 4'h0
`define RSA_REFOFF_RST 1'b0
`define RSA_UPPER_RST 16'hFFFF
`define RSA_LOWER_RST 16'h0000
`define RSA_FLAGS_RST 4'h0
`define RSA_WORD_ZERO 32'h0000_0000

// range codes
`define RSA_RNG_BI_3P0 4'h0
`define RSA_RNG_BI_0P625 4'h4
`define RSA_RNG_UNI_3P0 4'h8
`define RSA_RNG_UNI_1P25 4'hB

`endif

// [rsa_pkg.sv]
package rsa_pkg;

    // one bit per alarm source; same order for live, latched, status and mask
    typedef struct packed {
        logic supply_low;
        logic supply_high;
        logic input_high;
        logic input_low;
    } rsa_alarm_s;

endpackage

// [rsa_regs.sv]
`timescale 1ns/100ps
`include "rsa_defines.svh"

module rsa_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic app_reset,
    input wire logic [15:0] conv_data,
    input wire logic conv_valid,
    input wire logic supply_low_in,
    input wire logic supply_high_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [3:0] range_code,
    output logic internal_ref_off,
    output logic [15:0] input_upper_limit,
    output logic [15:0] input_lower_limit,
    output logic any_latched_alarm,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // range codes that may be stored; anything else keeps the old range
    function automatic logic range_legal(input logic [3:0] code);
        range_legal = (code <= `RSA_RNG_BI_0P625) ||
            ((code >= `RSA_RNG_UNI_3P0) && (code <= `RSA_RNG_UNI_1P25));
    endfunction

    // merge the low two byte lanes of a write into a 16-bit field
    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
        lane16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    rsa_pkg::rsa_alarm_s live;
    rsa_pkg::rsa_alarm_s trip;
    rsa_pkg::rsa_alarm_s istat;
    rsa_pkg::rsa_alarm_s imask;
    rsa_pkg::rsa_alarm_s cond;
    rsa_pkg::rsa_alarm_s next_live;
    rsa_pkg::rsa_alarm_s next_trip;
    rsa_pkg::rsa_alarm_s next_istat;
    rsa_pkg::rsa_alarm_s next_imask;
    logic [3:0] next_range_code;
    logic next_internal_ref_off;
    logic [15:0] next_input_upper_limit;
    logic [15:0] next_input_lower_limit;
    logic [31:0] next_wb_dat_o;
    logic next_wb_ack_o;
    logic next_any_latched_alarm;
    logic next_irq;
    logic req;
    logic wr;
    logic rd;
    logic [31:0] range_word;
    logic [31:0] alarm_word;

    // bus request decode: one access per ack
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;

    // alarm conditions seen this cycle; input compared per conversion
    always_comb begin
        cond.supply_low = supply_low_in;
        cond.supply_high = supply_high_in;
        cond.input_high = conv_valid && (conv_data > input_upper_limit);
        cond.input_low = conv_valid && (conv_data < input_lower_limit);
    end

    // read views of the two documented registers, reserved bits zero
    always_comb begin
        range_word = `RSA_WORD_ZERO;
        range_word[`RSA_RANGE_MSB:`RSA_RANGE_LSB] = range_code;
        range_word[`RSA_REFOFF_BIT] = internal_ref_off;
        alarm_word = `RSA_WORD_ZERO;
        alarm_word[`RSA_ACT_SUP_LOW_BIT] = live.supply_low;
        alarm_word[`RSA_ACT_SUP_HIGH_BIT] = live.supply_high;
        alarm_word[`RSA_ACT_IN_HIGH_BIT] = live.input_high;
        alarm_word[`RSA_ACT_IN_LOW_BIT] = live.input_low;
        alarm_word[`RSA_TRP_MSB:`RSA_TRP_LSB] = trip;
        alarm_word[`RSA_SUM_BIT] = any_latched_alarm;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next values

    // register writes, flag updates and bus answer
    always_comb begin
        next_range_code = range_code;
        next_internal_ref_off = internal_ref_off;
        next_input_upper_limit = input_upper_limit;
        next_input_lower_limit = input_lower_limit;
        next_imask = imask;
        next_istat = istat;
        next_live = live;
        next_trip = trip;
        // live input flags update on each conversion, supply flags always
        next_live.supply_low = cond.supply_low;
        next_live.supply_high = cond.supply_high;
        if (conv_valid) begin
            next_live.input_high = cond.input_high;
            next_live.input_low = cond.input_low;
        end
        // latched flags clear on alarm read; a new condition wins
        if (rd && wb_adr_i == `RSA_OFS_ALARM) begin
            next_trip = `RSA_FLAGS_RST;
        end
        if (wr && wb_adr_i == `RSA_OFS_ISTAT && wb_sel_i[0]) begin
            next_istat = istat & ~wb_dat_i[3:0];
        end
        if (wr) begin
            unique case (wb_adr_i)
                `RSA_OFS_RANGE: begin
                    if (wb_sel_i[0]) begin
                        next_internal_ref_off = wb_dat_i[`RSA_REFOFF_BIT];
                        if (range_legal(wb_dat_i[`RSA_RANGE_MSB:`RSA_RANGE_LSB])) begin
                            next_range_code = wb_dat_i[`RSA_RANGE_MSB:`RSA_RANGE_LSB];
                        end
                    end
                end
                `RSA_OFS_UPPER: begin
                    next_input_upper_limit = lane16(input_upper_limit, wb_dat_i, wb_sel_i);
                end
                `RSA_OFS_LOWER: begin
                    next_input_lower_limit = lane16(input_lower_limit, wb_dat_i, wb_sel_i);
                end
                `RSA_OFS_IMASK: begin
                    if (wb_sel_i[0]) begin
                        next_imask = wb_dat_i[3:0];
                    end
                end
                default: begin
                    // alarm register and unmapped writes are dropped
                end
            endcase
        end
        // application reset: all but range and live flags to defaults
        if (app_reset) begin
            next_internal_ref_off = `RSA_REFOFF_RST;
            next_input_upper_limit = `RSA_UPPER_RST;
            next_input_lower_limit = `RSA_LOWER_RST;
            next_trip = `RSA_FLAGS_RST;
            next_istat = `RSA_FLAGS_RST;
            next_imask = `RSA_FLAGS_RST;
        end else begin
            next_istat = next_istat | (cond & ~trip);
            next_trip = next_trip | cond;
        end
        next_any_latched_alarm = |next_trip;
        next_irq = |(next_istat & next_imask);
        // single-cycle answer; unmapped reads return zero
        next_wb_ack_o = req;
        next_wb_dat_o = `RSA_WORD_ZERO;
        if (rd) begin
            unique case (wb_adr_i)
                `RSA_OFS_RANGE: next_wb_dat_o = range_word;
                `RSA_OFS_ALARM: next_wb_dat_o = alarm_word;
                `RSA_OFS_UPPER: next_wb_dat_o = {16'h0000, input_upper_limit};
                `RSA_OFS_LOWER: next_wb_dat_o = {16'h0000, input_lower_limit};
                `RSA_OFS_ISTAT: next_wb_dat_o = {28'h0000000, istat};
                `RSA_OFS_IMASK: next_wb_dat_o = {28'h0000000, imask};
                default: next_wb_dat_o = `RSA_WORD_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    // range code: power-on reset only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            range_code <= `RSA_RANGE_RST;
        end else begin
            range_code <= next_range_code;
        end
    end

    // everything else
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            internal_ref_off <= `RSA_REFOFF_RST;
            input_upper_limit <= `RSA_UPPER_RST;
            input_lower_limit <= `RSA_LOWER_RST;
            live <= `RSA_FLAGS_RST;
            trip <= `RSA_FLAGS_RST;
            istat <= `RSA_FLAGS_RST;
            imask <= `RSA_FLAGS_RST;
            any_latched_alarm <= 1'b0;
            irq <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= `RSA_WORD_ZERO;
        end else begin
            internal_ref_off <= next_internal_ref_off;
            input_upper_limit <= next_input_upper_limit;
            input_lower_limit <= next_input_lower_limit;
            live <= next_live;
            trip <= next_trip;
            istat <= next_istat;
            imask <= next_imask;
            any_latched_alarm <= next_any_latched_alarm;
            irq <= next_irq;
            wb_ack_o <= next_wb_ack_o;
            wb_dat_o <= next_wb_dat_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_range_legal;
        @(posedge clk) disable iff (!resetn)
        1'b1 |-> range_legal(range_code);
    endproperty
    a_range_legal: assert property (p_range_legal) else $error("illegal range code held");

    property p_range_write;
        @(posedge clk) disable iff (!resetn)
        (wr && wb_adr_i == `RSA_OFS_RANGE && wb_sel_i[0] && range_legal(wb_dat_i[3:0]))
            |=> (range_code == $past(wb_dat_i[3:0])) && wb_ack_o;
    endproperty
    a_range_write: assert property (p_range_write) else $error("range write lost");

    property p_ref_off;
        @(posedge clk) disable iff (!resetn)
        (wr && wb_adr_i == `RSA_OFS_RANGE && wb_sel_i[0] && !app_reset)
            |=> internal_ref_off == $past(wb_dat_i[6]);
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference disable not stored");

    property p_reserved_zero;
        @(posedge clk) disable iff (!resetn)
        (rd && wb_adr_i == `RSA_OFS_RANGE) |=> wb_ack_o && (wb_dat_o[31:7] == 25'h0000000)
            && (wb_dat_o[5:4] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_app_keeps_range;
        @(posedge clk) disable iff (!resetn)
        (app_reset && !wr) |=> range_code == $past(range_code) && !internal_ref_off;
    endproperty
    a_app_keeps_range: assert property (p_app_keeps_range) else $error("range changed");

    property p_supply_live;
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> live.supply_low == $past(supply_low_in)
            && live.supply_high == $past(supply_high_in);
    endproperty
    a_supply_live: assert property (p_supply_live) else $error("supply flag stale");

    property p_input_high;
        @(posedge clk) disable iff (!resetn)
        (conv_valid && conv_data > input_upper_limit && !app_reset) |=> live.input_high ##1
            (trip.input_high || $past(rd && wb_adr_i == `RSA_OFS_ALARM));
    endproperty
    a_input_high: assert property (p_input_high) else $error("input high alarm missed");

    property p_trip_hold;
        @(posedge clk) disable iff (!resetn)
        !(rd && wb_adr_i == `RSA_OFS_ALARM) && !app_reset |=> (trip & $past(trip)) == $past(trip);
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("latched flag dropped");

    property p_summary;
        @(posedge clk) disable iff (!resetn)
        1'b1 |-> any_latched_alarm == (|trip);
    endproperty
    a_summary: assert property (p_summary) else $error("summary flag wrong");

    property p_ack_pulse;
        @(posedge clk) disable iff (!resetn)
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");

    property p_irq;
        @(posedge clk) disable iff (!resetn)
        1'b1 |-> irq == (|(istat & imask));
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with status and mask");

endmodule

// [tb_rsa_regs.sv]
`timescale 1ns/100ps
`include "rsa_defines.svh"

module tb_rsa_regs;
    logic clk, resetn, app_reset, conv_valid, supply_low_in, supply_high_in;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, internal_ref_off, any_latched_alarm, irq;
    logic [15:0] conv_data, input_upper_limit, input_lower_limit, u, l;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, range_code;
    logic [31:0] wb_dat_i, wb_dat_o, rd, wd, tmp;
    logic [3:0] m_range, m_live, m_trip, m_istat, m_imask;
    logic m_ref;
    int bad_count, num_checks, seed, cycles;

`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end

    rsa_regs dut (.clk(clk), .resetn(resetn), .app_reset(app_reset), .conv_data(conv_data),
        .conv_valid(conv_valid), .supply_low_in(supply_low_in),
        .supply_high_in(supply_high_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .range_code(range_code),
        .internal_ref_off(internal_ref_off), .input_upper_limit(input_upper_limit),
        .input_lower_limit(input_lower_limit), .any_latched_alarm(any_latched_alarm),
        .irq(irq));

////////////////////////////////////////////////////////////////////////////////
    // free-running clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // hang guard: a stuck handshake ends the run as a failure
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one classic cycle; request held up to the edge at which ack is seen high
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask

    // model view of the alarm word; a read empties the latched flags
    task automatic rd_alarm();
        rd_chk(`RSA_OFS_ALARM, {16'h0000, m_live[3:2], 2'b00, m_live[1:0], 2'b00, m_trip,
            3'b000, |m_trip}, "alarm_word");
        m_trip = 4'h0;
    endtask

    // one conversion; strict compare against both limits
    task automatic conv(input logic [15:0] d);
        @(posedge clk);
        conv_valid <= 1'b1;
        conv_data <= d;
        @(posedge clk);
        conv_valid <= 1'b0;
        conv_data <= ~d;
        m_live[1:0] = {d > m_up_l(), d < m_lo_l()};
        m_trip |= m_live;
        m_istat |= m_live;
    endtask

    function automatic logic [15:0] m_up_l();
        return u;
    endfunction

    function automatic logic [15:0] m_lo_l();
        return l;
    endfunction

////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        seed = 32'h0000_B629;
        {resetn, app_reset, conv_valid, supply_low_in, supply_high_in} = 5'b00000;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        conv_data = 16'h0000;
        {m_range, m_live, m_trip, m_istat, m_imask, m_ref} = '0;
        u = 16'hFFFF;
        l = 16'h0000;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(`RSA_OFS_RANGE, 32'h0000_0000, "range_rst");
        rd_alarm();
        rd_chk(`RSA_OFS_UPPER, 32'h0000_FFFF, "upper_rst");
        rd_chk(`RSA_OFS_LOWER, 32'h0000_0000, "lower_rst");
        // every range code, reserved bits set at random
        for (int c = 0; c < 16; c++) begin
            tmp = $random(seed);
            wd = {tmp[31:4], c[3:0]};
            if (c <= 4 || (c >= 8 && c <= 11))
                m_range = c[3:0];
            m_ref = wd[6];
            wb(1'b1, `RSA_OFS_RANGE, wd);
            `CHK("range_code", m_range, range_code)
            `CHK("ref_off", m_ref, internal_ref_off)
            rd_chk(`RSA_OFS_RANGE, {25'h0, m_ref, 2'b00, m_range}, "range_reg");
        end
        // alarm word is not writable; unmapped place reads zero
        wb(1'b1, `RSA_OFS_ALARM, 32'hFFFF_FFFF);
        rd_alarm();
        wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        rd_chk(8'h3C, 32'h0000_0000, "unmapped");
        // supply alarms: live follows the pin, latched stays after it falls
        supply_low_in <= 1'b1;
        supply_high_in <= 1'b1;
        m_live[3:2] = 2'b11;
        m_trip[3:2] = 2'b11;
        m_istat[3:2] = 2'b11;
        rd_chk(`RSA_OFS_ALARM, 32'h0000_C0C1, "alarm_live");
        supply_high_in <= 1'b0;
        supply_low_in <= 1'b0;
        m_live[3:2] = 2'b00;
        m_trip[3:2] = 2'b11;
        repeat (2) @(posedge clk);
        `CHK("summary", 1'b1, any_latched_alarm)
        rd_alarm();
        rd_alarm();
        // interrupt: unmasked status raises irq, mask drops it, writing one clears status
        m_imask = 4'h8;
        wb(1'b1, `RSA_OFS_IMASK, {28'h0, m_imask});
        `CHK("irq_on", |(m_istat & m_imask), irq)
        m_imask = 4'h2;
        wb(1'b1, `RSA_OFS_IMASK, {28'h0, m_imask});
        `CHK("irq_masked", |(m_istat & m_imask), irq)
        wb(1'b1, `RSA_OFS_ISTAT, 32'h0000_0008);
        m_istat[3] = 1'b0;
        rd_chk(`RSA_OFS_ISTAT, {28'h0, m_istat}, "istat");
        // input alarms around random limits, boundaries included
        tmp = $random(seed);
        u = {1'b1, tmp[14:0]};
        l = {1'b0, tmp[30:16]};
        if (u == 16'hFFFF)
            u = 16'hFFFE;
        if (l == 16'h0000)
            l = 16'h0001;
        wb(1'b1, `RSA_OFS_UPPER, {16'h0000, u});
        wb(1'b1, `RSA_OFS_LOWER, {16'h0000, l});
        `CHK("upper_port", u, input_upper_limit)
        `CHK("lower_port", l, input_lower_limit)
        conv(u);
        rd_alarm();
        conv(u + 16'h0001);
        repeat (2) @(posedge clk);
        `CHK("irq_input", |(m_istat & m_imask), irq)
        rd_alarm();
        conv(l - 16'h0001);
        conv(l);
        rd_alarm();
        // application reset keeps the range, restores limits and ref bit to defaults, drops irq
        wb(1'b1, `RSA_OFS_RANGE, 32'h0000_0049);
        @(posedge clk);
        app_reset <= 1'b1;
        @(posedge clk);
        app_reset <= 1'b0;
        rd_chk(`RSA_OFS_RANGE, 32'h0000_0009, "range_kept");
        rd_chk(`RSA_OFS_UPPER, 32'h0000_FFFF, "upper_app");
        rd_chk(`RSA_OFS_LOWER, 32'h0000_0000, "lower_app");
        `CHK("irq_app", 1'b0, irq)
        // a power-on reset in mid-run clears the range that application reset kept
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(`RSA_OFS_RANGE, 32'h0000_0000, "range_por");
        `CHK("ref_por", 1'b0, internal_ref_off)
        give_verdict();
    end
endmodule
